/* File: cmp_filt_defs.svh */
`ifndef CMP_FILT_DEFS_SVH
`define CMP_FILT_DEFS_SVH

// field widths
`define CNT_W 3
`define PER_W 8
// register byte offsets
`define OFS_CTRL_ZERO 4'h0
`define OFS_CTRL_ONE 4'h4
`define OFS_PERIOD 4'h8
`define OFS_STATUS 4'hC
// control_reg_one bit positions
`define BIT_EN 0
`define BIT_WE 1
`define BIT_SAMPLE 2
// status bit positions
`define BIT_RAW 0
`define BIT_UNFILT 1
`define BIT_FINAL 2
`define MODE_LSB 4
`define MODE_MSB 7
// special field values and reset values
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1
`define PER_ZERO 8'h00
`define PER_ONE 8'h01
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: cmp_filt_pkg.sv */
`include "cmp_filt_defs.svh"
package cmp_filt_pkg;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef logic [`PER_W-1:0] per_t;
  // operating modes; illegal covers every unlisted setting
  typedef enum logic [3:0] {
    M_DISABLED, M_CONTINUOUS, M_SAMP_EXT, M_SAMP_INT, M_FILT_EXT,
    M_FILT_INT, M_WINDOWED, M_WIN_RESAMP, M_WIN_FILT, M_ILLEGAL
  } mode_t;

  // mode from the control fields
  function automatic mode_t decode_mode(input logic en, input logic we, input logic se,
                                        input cnt_t cnt, input per_t per);
    mode_t m;
    m = M_ILLEGAL;
    if (!en) begin
      m = M_DISABLED;
    end else if (!we && se) begin
      if (cnt == `CNT_ONE) m = M_SAMP_EXT;
      else if (cnt > `CNT_ONE) m = M_FILT_EXT;
    end else if (!we) begin
      if (cnt == `CNT_ZERO || per == `PER_ZERO) m = M_CONTINUOUS;
      else if (cnt == `CNT_ONE) m = M_SAMP_INT;
      else m = M_FILT_INT;
    end else if (!se) begin
      if (cnt == `CNT_ZERO || per == `PER_ZERO) m = M_WINDOWED;
      else if (cnt == `CNT_ONE) m = M_WIN_RESAMP;
      else m = M_WIN_FILT;
    end
    return m;
  endfunction
endpackage

/* File: filt_if.sv */
`timescale 1ns/10ps
// link between the mode logic and the sample filter
interface filt_if;
  logic tick; // one sample strobe
  logic data; // value being sampled
  logic clear; // forces filter to its known state
  cmp_filt_pkg::cnt_t count; // agreeing samples needed
  logic out; // filter result
  modport ctrl(output tick, output data, output clear, output count, input out);
  modport filt(input tick, input data, input clear, input count, output out);
endinterface

/* File: sample_ticker.sv */
`timescale 1ns/10ps
`include "cmp_filt_defs.svh"
// internal sample clock: one strobe every period bus clocks
module sample_ticker (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset, active low
  input wire logic clear, // holds the divider at zero
  input wire cmp_filt_pkg::per_t period, // interval in bus clocks
  output logic tick // one-cycle strobe
);
  cmp_filt_pkg::per_t cnt; // cycles since last strobe

  ////////////////////////////////////////////////////////////////
  // divider; period zero never reaches here since clear is held
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt <= `PER_ZERO;
      tick <= 1'b0;
    end else if (cnt >= period - `PER_ONE) begin
      cnt <= `PER_ZERO;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + `PER_ONE;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tick_space_a: assert property (
    (tick && !clear && period > `PER_ONE) |=> !tick) else $error("strobes too close");
endmodule

/* File: sample_filter.sv */
`timescale 1ns/10ps
`include "cmp_filt_defs.svh"
// agreement filter: output follows input after count equal samples
module sample_filter (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset, active low
  filt_if.filt fb // strobe, data, count in; result out
);
  logic cand; // value of the current run
  cmp_filt_pkg::cnt_t agree; // length of the run, saturating
  logic [`CNT_W:0] run; // run length including this sample

  // one bit wider so a full run cannot wrap
  always_comb begin
    if (fb.data == cand && agree != `CNT_ZERO) run = {1'b0, agree} + {`CNT_W'h0, 1'b1};
    else run = {`CNT_W'h0, 1'b1};
  end

  ////////////////////////////////////////////////////////////////
  // run tracking; clear gives the known start state
  always_ff @(posedge aclk) begin
    if (!aresetn || fb.clear) begin
      cand <= 1'b0;
      agree <= `CNT_ZERO;
    end else if (fb.tick) begin
      cand <= fb.data;
      agree <= (run > {1'b0, fb.count}) ? fb.count : run[`CNT_W-1:0];
    end
  end

  // result only moves once enough samples agree; zero until filled
  always_ff @(posedge aclk) begin
    if (!aresetn || fb.clear) begin
      fb.out <= 1'b0;
    end else if (fb.tick && run >= {1'b0, fb.count}) begin
      fb.out <= fb.data;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  plain_sampler_a: assert property (
    (fb.tick && !fb.clear && fb.count == `CNT_ONE) |=> fb.out == $past(fb.data))
    else $error("count one is not a plain sampler");
  lone_sample_a: assert property (
    (fb.tick && !fb.clear && fb.count > `CNT_ONE && (fb.data != cand || agree == `CNT_ZERO))
    |=> $stable(fb.out)) else $error("single sample moved the filter");
  filter_empty_a: assert property (
    fb.clear |=> !fb.out) else $error("filter not empty after clear");
endmodule

/* File: comparator_sample_filter_modes.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "cmp_filt_defs.svh"
// comparator output conditioning with an axi4-lite register slave
module comparator_sample_filter_modes #(
  parameter int ADDR_W = 4 // axi address width
) (
  input wire logic aclk, // bus clock, 100 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic compare_level, // analog comparator decision, async
  input wire logic window_in, // window gating pin, async
  input wire logic sample_in, // external sample pin, async
  output logic raw_compare_out, // comparator result, zero when disabled
  output logic unfiltered_out, // windowed or direct result
  output logic final_filtered_out // sampled and filtered result
);
  ////////////////////////////////////////////////////////////////
  // declarations
  cmp_filt_pkg::cnt_t filter_sample_count; // control_reg_zero field
  logic enable_bit; // control_reg_one: module enable
  logic window_enable_bit; // control_reg_one: window gating
  logic sample_enable_bit; // control_reg_one: external sampling
  cmp_filt_pkg::per_t filter_sample_period; // filter_period_reg field
  cmp_filt_pkg::mode_t mode; // decoded operating mode
  logic cmp_meta, cmp_sync; // comparator synchroniser
  logic win_meta, win_sync; // window synchroniser
  logic smp_meta, smp_sync, smp_prev; // sample pin synchroniser and edge
  logic ext_rise; // rising edge of the sample pin
  logic per_tick; // internal period strobe
  logic filter_mode; // a mode that uses the filter
  logic windowed_any; // any windowed mode
  logic reconfig_hold; // safe reconfiguration setting
  logic next_unfilt; // next value of unfiltered_out
  logic aw_held, w_held; // write halves captured
  logic [ADDR_W-1:0] wr_addr; // captured write address
  logic [31:0] wr_data; // captured write data
  logic wr_lane0; // captured low byte enable
  logic do_write; // both halves present, commit now
  logic [31:0] next_rdata; // read mux output
  filt_if fb(); // filter link

  // register decode shared by reads and writes
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] lo;
    lo = a[3:0];
    return (lo == `OFS_CTRL_ZERO) || (lo == `OFS_CTRL_ONE) ||
           (lo == `OFS_PERIOD) || (lo == `OFS_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  // a held half stalls its channel until the
  // response is taken: one write at a time
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  // address half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // data half; fields all sit in the low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= 32'h0;
      wr_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wr_data <= wdata;
      wr_lane0 <= wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // response; unmapped addresses answer slverr and change nothing
  // bvalid blocks both halves until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers written by software; status is read only
  // wstrb[0] low: answered okay, nothing written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_sample_count <= `CNT_ZERO;
    end else if (do_write && wr_lane0 && wr_addr[3:0] == `OFS_CTRL_ZERO) begin
      filter_sample_count <= wr_data[`CNT_W-1:0];
    end
  end

  // enable, window enable, sample enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_bit <= 1'b0;
      window_enable_bit <= 1'b0;
      sample_enable_bit <= 1'b0;
    end else if (do_write && wr_lane0 && wr_addr[3:0] == `OFS_CTRL_ONE) begin
      enable_bit <= wr_data[`BIT_EN];
      window_enable_bit <= wr_data[`BIT_WE];
      sample_enable_bit <= wr_data[`BIT_SAMPLE];
    end
  end

  // internal sample period in bus clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_sample_period <= `PER_ZERO;
    end else if (do_write && wr_lane0 && wr_addr[3:0] == `OFS_PERIOD) begin
      filter_sample_period <= wr_data[`PER_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi read channel: one cycle from address to data
  // rdata is never overwritten while unread
  assign arready = !rvalid;

  always_comb begin
    next_rdata = 32'h0;
    if (araddr[3:0] == `OFS_CTRL_ZERO) begin
      next_rdata[`CNT_W-1:0] = filter_sample_count;
    end else if (araddr[3:0] == `OFS_CTRL_ONE) begin
      next_rdata[`BIT_EN] = enable_bit;
      next_rdata[`BIT_WE] = window_enable_bit;
      next_rdata[`BIT_SAMPLE] = sample_enable_bit;
    end else if (araddr[3:0] == `OFS_PERIOD) begin
      next_rdata[`PER_W-1:0] = filter_sample_period;
    end else if (araddr[3:0] == `OFS_STATUS) begin
      next_rdata[`BIT_RAW] = raw_compare_out;
      next_rdata[`BIT_UNFILT] = unfiltered_out;
      next_rdata[`BIT_FINAL] = final_filtered_out;
      next_rdata[`MODE_MSB:`MODE_LSB] = mode;
    end
  end

  // data held until the master takes it
  // status is a snapshot taken at the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= is_mapped(araddr) ? next_rdata : 32'h0;
      rresp <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is read by logic
  // the comparator is async as well, so it pays
  // the same two-flop latency as the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      win_meta <= 1'b0;
      win_sync <= 1'b0;
      smp_meta <= 1'b0;
      smp_sync <= 1'b0;
      smp_prev <= 1'b0;
    end else begin
      cmp_meta <= compare_level;
      cmp_sync <= cmp_meta;
      win_meta <= window_in;
      win_sync <= win_meta;
      smp_meta <= sample_in;
      smp_sync <= smp_meta;
      smp_prev <= smp_sync;
    end
  end

  ////////////////////////////////////////////////////////////////
  // mode decoding; illegal settings drive unfiltered_out and final_filtered_out low, raw_compare_out still follows the comparator
  // holding illegal settings low beats guessing
  // which mode software meant
  assign mode = cmp_filt_pkg::decode_mode(enable_bit, window_enable_bit, sample_enable_bit,
                                          filter_sample_count, filter_sample_period);
  assign ext_rise = smp_sync && !smp_prev;
  assign windowed_any = (mode == cmp_filt_pkg::M_WINDOWED) ||
                        (mode == cmp_filt_pkg::M_WIN_RESAMP) ||
                        (mode == cmp_filt_pkg::M_WIN_FILT);
  assign filter_mode = (mode == cmp_filt_pkg::M_SAMP_EXT) || (mode == cmp_filt_pkg::M_SAMP_INT) ||
                       (mode == cmp_filt_pkg::M_FILT_EXT) || (mode == cmp_filt_pkg::M_FILT_INT) ||
                       (mode == cmp_filt_pkg::M_WIN_RESAMP) || (mode == cmp_filt_pkg::M_WIN_FILT);
  assign reconfig_hold = !sample_enable_bit && filter_sample_count == `CNT_ZERO;

  // internal period divider, stopped outside filtering modes
  // cleared while the pin is the source, so an
  // internal-period mode starts from zero
  sample_ticker u_ticker (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(!filter_mode || sample_enable_bit),
    .period(filter_sample_period),
    .tick(per_tick)
  );

  // filter clock source: sample pin edges or the period strobe
  assign fb.tick = filter_mode && (sample_enable_bit ? ext_rise : per_tick);
  assign fb.data = unfiltered_out;
  assign fb.count = filter_sample_count;
  // reconfiguration setting or a non-filter mode empties the filter
  // trade-off: leaving the filter modes loses the run, but
  // a filtered mode entered from a non-filter mode starts empty
  assign fb.clear = reconfig_hold || !filter_mode;

  sample_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .fb(fb)
  );

  ////////////////////////////////////////////////////////////////
  // unfiltered path: low when disabled or illegal, else direct when not windowed, follows while window high, held while window low
  // one flop is output and window latch: a new
  // windowed mode starts from the old value
  always_comb begin
    if (!enable_bit || mode == cmp_filt_pkg::M_ILLEGAL) begin
      next_unfilt = 1'b0;
    end else if (windowed_any) begin
      next_unfilt = win_sync ? cmp_sync : unfiltered_out;
    end else begin
      next_unfilt = cmp_sync;
    end
  end

  // raw result forced low when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_compare_out <= 1'b0;
    end else begin
      raw_compare_out <= enable_bit ? cmp_sync : 1'b0;
    end
  end

  // unfiltered output register, doubles as the window latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unfiltered_out <= 1'b0;
    end else begin
      unfiltered_out <= next_unfilt;
    end
  end

  // final output: direct copy, or the filter result in sampled modes
  // both outputs move on the same edge, so
  // continuous and windowed read identical
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      final_filtered_out <= 1'b0;
    end else if (mode == cmp_filt_pkg::M_CONTINUOUS || mode == cmp_filt_pkg::M_WINDOWED) begin
      final_filtered_out <= next_unfilt;
    end else if (filter_mode) begin
      final_filtered_out <= fb.out;
    end else begin
      final_filtered_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // window phases as seen after the synchroniser
  sequence win_open;
    windowed_any && win_sync;
  endsequence
  sequence win_shut;
    windowed_any && !win_sync;
  endsequence

  raw_disabled_a: assert property (
    !enable_bit |=> !raw_compare_out) else $error("raw result high while disabled");
  cont_pass_a: assert property (
    (mode == cmp_filt_pkg::M_CONTINUOUS) |=> final_filtered_out == $past(cmp_sync))
    else $error("continuous mode not passing through");
  cont_same_a: assert property (
    (mode == cmp_filt_pkg::M_CONTINUOUS) |=> final_filtered_out == unfiltered_out)
    else $error("continuous outputs differ");
  win_take_a: assert property (
    win_open |=> unfiltered_out == $past(cmp_sync)) else $error("window open, result not taken");
  win_hold_a: assert property (
    win_shut |=> $stable(unfiltered_out)) else $error("window shut, latch moved");
  ext_edge_a: assert property (
    (sample_enable_bit && !ext_rise) |-> !fb.tick) else $error("sample without pin edge");
  int_source_a: assert property (
    (filter_mode && !sample_enable_bit) |-> fb.tick == per_tick)
    else $error("internal strobe not used");
  reconfig_clear_a: assert property (
    reconfig_hold |=> !fb.out) else $error("filter not reset on reconfiguration");
  wfilt_follow_a: assert property (
    (mode == cmp_filt_pkg::M_WIN_FILT) ##1 (mode == cmp_filt_pkg::M_WIN_FILT)
    |-> final_filtered_out == $past(fb.out)) else $error("windowed filter result lost");

  // disabled, sampled and filling phases at the outputs
  final_off_a: assert property (
    !enable_bit |=> !final_filtered_out) else $error("final result high while disabled");
  unfilt_off_a: assert property (
    !enable_bit |=> !unfiltered_out) else $error("unfiltered result high while disabled");
  samp_direct_a: assert property (
    (filter_mode && !windowed_any) |=> unfiltered_out == $past(cmp_sync))
    else $error("sampled input not taken directly");
  fill_zero_a: assert property (
    (filter_mode && !fb.out) |=> !final_filtered_out) else $error("final high before fill");
endmodule

/* File: comparator_front_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far side: comparator decision plus window and sample pins
// pins move 3 ns after the clock edge, so they are never aligned to the
// design's sampling edge, as with a real analog source
module comparator_front_model (
  input wire logic aclk, // bus clock
  input wire logic level_req, // wanted comparator decision
  input wire logic window_req, // wanted window level
  input wire logic sample_req, // wanted sample pin level
  output logic compare_level, // comparator decision pin
  output logic window_in, // window gating pin
  output logic sample_in // external sample pin
);
  ////////////////////////////////////////////////////////////////////////////////
  // all pins low at power up
  initial begin
    compare_level = 1'b0;
    window_in = 1'b0;
    sample_in = 1'b0;
  end
  // follow the requests with a lag off the clock edge
  always @(posedge aclk) begin
    compare_level <= #3 level_req;
    window_in <= #3 window_req;
    sample_in <= #3 sample_req;
  end
endmodule

/* File: comparator_sample_filter_modes_bench.sv */
`timescale 1ns/10ps
`include "cmp_filt_defs.svh"
// one compare: counts it and reports a mismatch at once
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, sn); end end
module comparator_sample_filter_modes_bench;
  ////////////////////////////////////////////////////////////////////////////////
  logic aclk = 1'b0; // bus clock
  logic aresetn; // sync reset, active low
  logic [3:0] awaddr, araddr; // bus addresses
  logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [31:0] wdata, rdata, rv; // data and last read value
  logic [3:0] wstrb; // byte enables
  logic [1:0] bresp, rresp; // responses
  logic level_req, window_req, sample_req; // requests to the far side
  logic compare_level, window_in, sample_in; // pins from the far side
  logic raw_compare_out, unfiltered_out, final_filtered_out; // results
  int fail_count = 0; // mismatches
  int checks_done = 0; // comparisons made
  int cycles = 0; // timeout counter
  // mode table: control bits, count, period, expected mode code
  logic [17:0] tbl [13] = '{{3'h0, 3'h5, 8'h09, 4'h0}, {3'h1, 3'h0, 8'h07, 4'h1},
    {3'h1, 3'h3, 8'h00, 4'h1}, {3'h5, 3'h1, 8'h00, 4'h2}, {3'h1, 3'h1, 8'h01, 4'h3},
    {3'h5, 3'h7, 8'h00, 4'h4}, {3'h1, 3'h2, 8'hFF, 4'h5}, {3'h3, 3'h0, 8'h04, 4'h6},
    {3'h3, 3'h2, 8'h00, 4'h6}, {3'h3, 3'h1, 8'hFF, 4'h7}, {3'h3, 3'h7, 8'h01, 4'h8},
    {3'h7, 3'h1, 8'h01, 4'h9}, {3'h5, 3'h0, 8'h00, 4'h9}};

  always #5 aclk = ~aclk;

  comparator_sample_filter_modes comparator_sample_filter_modes_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .compare_level(compare_level), .window_in(window_in), .sample_in(sample_in),
    .raw_compare_out(raw_compare_out), .unfiltered_out(unfiltered_out),
    .final_filtered_out(final_filtered_out));

  comparator_front_model comparator_front_model_inst (
    .aclk(aclk), .level_req(level_req), .window_req(window_req), .sample_req(sample_req),
    .compare_level(compare_level), .window_in(window_in), .sample_in(sample_in));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, reached from the main sequence or the timeout
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hang costs a mismatch; the run needs far fewer cycles than this
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] ex);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    `CHK("bresp", ex, bresp);
    @(posedge aclk); // idle edge between calls
  endtask

  // bus read: rready held until the answer is seen
  task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] ex);
    logic ar_ok;
    ar_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    d = rdata;
    rready <= 1'b0;
    `CHK("rresp", ex, rresp);
    @(posedge aclk); // idle edge between calls
  endtask

  // safe reconfiguration: sample enable off and count zero come first
  task automatic set_mode(input logic [2:0] ctl, input logic [2:0] cnt, input logic [7:0] per);
    wr(`OFS_CTRL_ONE, {29'h0, ctl & 3'h3}, `RESP_OKAY);
    wr(`OFS_CTRL_ZERO, 32'h0, `RESP_OKAY);
    wr(`OFS_PERIOD, {24'h0, per}, `RESP_OKAY);
    wr(`OFS_CTRL_ZERO, {29'h0, cnt}, `RESP_OKAY);
    wr(`OFS_CTRL_ONE, {29'h0, ctl}, `RESP_OKAY);
  endtask

  // one rising edge on the sample pin; leaves the pin high
  task automatic pulse();
    sample_req <= 1'b0;
    cyc(4);
    sample_req <= 1'b1;
    cyc(12);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {level_req, window_req, sample_req} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and unmapped places
    for (int i = 0; i < 4; i++) begin
      rd(4'(4 * i), rv, `RESP_OKAY);
      `CHK("reset value", 32'h0, rv);
    end
    rd(4'h2, rv, `RESP_SLVERR);
    `CHK("unmapped rdata", 32'h0, rv);
    wr(4'h6, 32'h7, `RESP_SLVERR);
    // disabled: raw result stays low with the comparator high
    level_req <= 1'b1;
    cyc(8);
    `CHK("raw disabled", 1'b0, raw_compare_out);
    // every listed mode and two illegal settings
    for (int i = 0; i < 13; i++) begin
      set_mode(tbl[i][17:15], tbl[i][14:12], tbl[i][11:4]);
      rd(`OFS_STATUS, rv, `RESP_OKAY);
      `CHK("mode", tbl[i][3:0], rv[7:4]);
      rd(`OFS_CTRL_ZERO, rv, `RESP_OKAY);
      `CHK("count readback", {29'h0, tbl[i][14:12]}, rv);
    end
    // continuous: direct pass of the comparator
    set_mode(3'h1, 3'h0, 8'h00);
    cyc(8);
    `CHK("raw on", 1'b1, raw_compare_out);
    `CHK("cont unfilt", 1'b1, unfiltered_out);
    `CHK("cont final", 1'b1, final_filtered_out);
    level_req <= 1'b0;
    cyc(8);
    `CHK("cont final low", 1'b0, final_filtered_out);
    // internal filter, three samples: starts low, rejects a short glitch
    level_req <= 1'b1;
    set_mode(3'h1, 3'h3, 8'h04);
    `CHK("filter fill", 1'b0, final_filtered_out);
    cyc(40);
    `CHK("filter high", 1'b1, final_filtered_out);
    level_req <= 1'b0;
    cyc(2);
    level_req <= 1'b1;
    repeat (20) begin
      cyc(1);
      `CHK("glitch held", 1'b1, final_filtered_out);
    end
    level_req <= 1'b0;
    cyc(40);
    `CHK("filter low", 1'b0, final_filtered_out);
    // internal plain sampling
    set_mode(3'h1, 3'h1, 8'h05);
    level_req <= 1'b1;
    cyc(20);
    `CHK("sampled int", 1'b1, final_filtered_out);
    // external sampling: only rising edges of the pin take a sample
    set_mode(3'h5, 3'h1, 8'h00);
    cyc(20);
    `CHK("no edge", 1'b0, final_filtered_out);
    pulse();
    `CHK("edge taken", 1'b1, final_filtered_out);
    level_req <= 1'b0;
    cyc(20);
    `CHK("pin held high", 1'b1, final_filtered_out);
    pulse();
    `CHK("second edge", 1'b0, final_filtered_out);
    // external filter, two samples must agree
    set_mode(3'h5, 3'h2, 8'h00);
    level_req <= 1'b1;
    pulse();
    `CHK("one sample", 1'b0, final_filtered_out);
    pulse();
    `CHK("two samples", 1'b1, final_filtered_out);
    // windowed: follows while window high, holds while low
    set_mode(3'h3, 3'h0, 8'h00);
    window_req <= 1'b1;
    cyc(8);
    `CHK("win unfilt", 1'b1, unfiltered_out);
    `CHK("win final", 1'b1, final_filtered_out);
    window_req <= 1'b0;
    level_req <= 1'b0;
    cyc(8);
    `CHK("win hold", 1'b1, unfiltered_out);
    window_req <= 1'b1;
    cyc(8);
    `CHK("win reopen", 1'b0, unfiltered_out);
    // windowed resample, then windowed filter
    set_mode(3'h3, 3'h1, 8'h03);
    level_req <= 1'b1;
    cyc(20);
    `CHK("win resample", 1'b1, final_filtered_out);
    set_mode(3'h3, 3'h2, 8'h04);
    `CHK("win filt fill", 1'b0, final_filtered_out);
    cyc(30);
    `CHK("win filt", 1'b1, final_filtered_out);
    summarize();
  end
endmodule
